// File: src/bdctl_pkg.sv
// Shared constants of the board control and status register
package bdctl_pkg;

   // -------------------------------------------------------------
   // Address map
   // -------------------------------------------------------------
   localparam logic [6:0]  BOARD_CONTROL_OFS  = 7'h00;

   // -------------------------------------------------------------
   // Field positions
   // -------------------------------------------------------------
   localparam int          MODE_LSB           = 0;
   localparam int          RANGE_LSB          = 2;
   localparam int          OFFBIN_BIT         = 4;
   localparam int          INITIATOR_BIT      = 5;
   localparam int          SYNC_BIT           = 6;
   localparam int          CAL_BIT            = 7;
   localparam int          IRQ_SEL_LSB        = 8;
   localparam int          IRQ_FLAG_BIT       = 11;
   localparam int          CAL_PASS_BIT       = 12;
   localparam int          READY_BIT          = 13;
   localparam int          THRESH_BIT         = 14;
   localparam int          INIT_CMD_BIT       = 15;
   localparam int          UNSYNC_BIT         = 16;
   localparam int          CLR_ON_SYNC_BIT    = 17;
   localparam int          GEN_A_BIT          = 18;
   localparam int          LOW_FILTER_BIT     = 19;
   localparam int          TTL_SYNC_BIT       = 20;
   localparam int          ARM_TRIG_BIT       = 21;
   localparam int          INV_TRIG_BIT       = 23;

   // -------------------------------------------------------------
   // Reset and characteristic values
   // -------------------------------------------------------------
   localparam logic [31:0] BOARD_CONTROL_RST  = 32'h0000383c;
   localparam logic [31:0] BOARD_CONTROL_FULL = 32'h0000783c;

endpackage

// File: src/bdctl_reg.sv
// Board control and status register with its command sequencing
// Contract
// - Register sits at local offset zero
// - Reset readback is 0000383c
// - Reads 0000783c once buffer fills
// - Bits 1:0 input mode, default system
// - Bits 3:2 range, default widest range
// - Bit 4 offset binary, resets high
// - Bit 5 initiator or target, resets initiator
// - Bit 6 sync pulse, external if initiator
// - Bit 17 turns sync into buffer clear
// - Bit 7 calibrates, high until run completes
// - Bit 12 set at start, cleared on failure
// - Bits 10:8 interrupt event select, reset zero
// - Bit 11 set on request, host clears low
// - Bit 13 low while parameters change
// - Bit 14 shows buffer above threshold
// - Bit 15 starts board initialization
// - Bit 16 selects unsynchronized sampling
// - Bit 18 selects generator A clock out
// - Bit 19 low frequency image filter
// - Bit 20 logic level sync I/O
// - Bit 21 arms trigger, bit 23 inverts
module bdctl_reg
(
   input  wire logic        clk_in,
   input  wire logic        sys_rst_in,
   input  wire logic [6:0]  addr_in,
   input  wire logic        wr_in,
   input  wire logic        rd_in,
   input  wire logic [31:0] wdata_in,
   input  wire logic        irq_event_in,
   input  wire logic        cal_done_in,
   input  wire logic        cal_fail_in,
   input  wire logic        init_done_in,
   input  wire logic        chan_param_change_in,
   input  wire logic        adc_clk_stable_in,
   input  wire logic        buf_over_thresh_in,
   output logic      [31:0] rdata_out,
   output logic      [1:0]  input_mode_out,
   output logic      [1:0]  input_range_out,
   output logic             offset_binary_out,
   output logic             initiator_out,
   output logic      [2:0]  irq_select_out,
   output logic             irq_out,
   output logic             unsynced_sampling_out,
   output logic             gen_a_clock_out_select_out,
   output logic             low_freq_filter_out,
   output logic             ttl_sync_io_out,
   output logic             arm_trigger_out,
   output logic             invert_trigger_out,
   output logic             sync_local_out,
   output logic             ext_sync_out,
   output logic             buf_clear_out,
   output logic             cal_start_out,
   output logic             init_start_out
);

   // -------------------------------------------------------------
   // State
   // -------------------------------------------------------------
   typedef struct packed
   {
      logic [1:0]  mode;
      logic [1:0]  range;
      logic        offbin;
      logic        initiator;
      logic        cal_busy;
      logic [2:0]  irq_sel;
      logic        irq_flag;
      logic        cal_pass;
      logic        chan_ready;
      logic        thresh;
      logic        init_busy;
      logic        unsync;
      logic        clr_on_sync;
      logic        gen_a_sel;
      logic        low_filter;
      logic        ttl_sync;
      logic        arm_trig;
      logic        inv_trig;
      logic        sync_p;
      logic        ext_sync_p;
      logic        buf_clr_p;
      logic        cal_start_p;
      logic        init_start_p;
      logic [31:0] rdata;
   } bdctl_state_type;

   // Readable fields are taken from the reset word, except the busy and threshold bits, which start cleared
   function automatic bdctl_state_type defaults();
      bdctl_state_type r;
      r             = '0;
      r.mode        = bdctl_pkg::BOARD_CONTROL_RST[bdctl_pkg::MODE_LSB +: 2];
      r.range       = bdctl_pkg::BOARD_CONTROL_RST[bdctl_pkg::RANGE_LSB +: 2];
      r.offbin      = bdctl_pkg::BOARD_CONTROL_RST[bdctl_pkg::OFFBIN_BIT];
      r.initiator   = bdctl_pkg::BOARD_CONTROL_RST[bdctl_pkg::INITIATOR_BIT];
      r.irq_sel     = bdctl_pkg::BOARD_CONTROL_RST[bdctl_pkg::IRQ_SEL_LSB +: 3];
      r.irq_flag    = bdctl_pkg::BOARD_CONTROL_RST[bdctl_pkg::IRQ_FLAG_BIT];
      r.cal_pass    = bdctl_pkg::BOARD_CONTROL_RST[bdctl_pkg::CAL_PASS_BIT];
      r.chan_ready  = bdctl_pkg::BOARD_CONTROL_RST[bdctl_pkg::READY_BIT];
      r.unsync      = bdctl_pkg::BOARD_CONTROL_RST[bdctl_pkg::UNSYNC_BIT];
      r.clr_on_sync = bdctl_pkg::BOARD_CONTROL_RST[bdctl_pkg::CLR_ON_SYNC_BIT];
      r.gen_a_sel   = bdctl_pkg::BOARD_CONTROL_RST[bdctl_pkg::GEN_A_BIT];
      r.low_filter  = bdctl_pkg::BOARD_CONTROL_RST[bdctl_pkg::LOW_FILTER_BIT];
      r.ttl_sync    = bdctl_pkg::BOARD_CONTROL_RST[bdctl_pkg::TTL_SYNC_BIT];
      r.arm_trig    = bdctl_pkg::BOARD_CONTROL_RST[bdctl_pkg::ARM_TRIG_BIT];
      r.inv_trig    = bdctl_pkg::BOARD_CONTROL_RST[bdctl_pkg::INV_TRIG_BIT];
      return r;
   endfunction

   // Software sync bit always reads low; readback returns a constant zero there, not the pulse
   function automatic logic [31:0] readback(input bdctl_state_type s);
      readback = {8'h00, s.inv_trig, 1'b0, s.arm_trig, s.ttl_sync,
                  s.low_filter, s.gen_a_sel, s.clr_on_sync, s.unsync,
                  s.init_busy, s.thresh, s.chan_ready, s.cal_pass,
                  s.irq_flag, s.irq_sel, s.cal_busy, 1'b0, s.initiator,
                  s.offbin, s.range, s.mode};
   endfunction

   bdctl_state_type state_q;
   bdctl_state_type state_d;
   logic            hit;
   logic [31:0]     view;

   assign hit  = (addr_in == bdctl_pkg::BOARD_CONTROL_OFS);
   assign view = readback(state_q);

   // -------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------
   always_comb
   begin
      state_d              = state_q;
      // Completed initialization puts the configuration back to defaults;
      // status flags and the last read word survive, later updates still apply
      if (state_q.init_busy && init_done_in)
      begin
         state_d            = defaults();
         state_d.chan_ready = state_q.chan_ready;
         state_d.cal_pass   = state_q.cal_pass;
         state_d.cal_busy   = state_q.cal_busy;
         state_d.irq_flag   = state_q.irq_flag;
         state_d.rdata      = state_q.rdata;
      end
      state_d.sync_p       = 1'b0;
      state_d.ext_sync_p   = 1'b0;
      state_d.buf_clr_p    = 1'b0;
      state_d.cal_start_p  = 1'b0;
      state_d.init_start_p = 1'b0;
      state_d.thresh       = buf_over_thresh_in;
      if (chan_param_change_in)
      begin
         state_d.chan_ready = 1'b0;
      end
      else if (adc_clk_stable_in)
      begin
         state_d.chan_ready = 1'b1;
      end
      if (state_q.cal_busy && cal_done_in)
      begin
         state_d.cal_busy = 1'b0;
         if (cal_fail_in)
         begin
            state_d.cal_pass = 1'b0;
         end
      end
      if (wr_in && hit)
      begin
         state_d.mode        = wdata_in[bdctl_pkg::MODE_LSB +: 2];
         state_d.range       = wdata_in[bdctl_pkg::RANGE_LSB +: 2];
         state_d.offbin      = wdata_in[bdctl_pkg::OFFBIN_BIT];
         state_d.initiator   = wdata_in[bdctl_pkg::INITIATOR_BIT];
         state_d.irq_sel     = wdata_in[bdctl_pkg::IRQ_SEL_LSB +: 3];
         state_d.unsync      = wdata_in[bdctl_pkg::UNSYNC_BIT];
         state_d.clr_on_sync = wdata_in[bdctl_pkg::CLR_ON_SYNC_BIT];
         state_d.gen_a_sel   = wdata_in[bdctl_pkg::GEN_A_BIT];
         state_d.low_filter  = wdata_in[bdctl_pkg::LOW_FILTER_BIT];
         state_d.ttl_sync    = wdata_in[bdctl_pkg::TTL_SYNC_BIT];
         state_d.arm_trig    = wdata_in[bdctl_pkg::ARM_TRIG_BIT];
         state_d.inv_trig    = wdata_in[bdctl_pkg::INV_TRIG_BIT];
         if (!wdata_in[bdctl_pkg::IRQ_FLAG_BIT])
         begin
            state_d.irq_flag = 1'b0;
         end
         // Any change of channel parameters drops the ready flag
         if (wdata_in[bdctl_pkg::MODE_LSB +: 2] != state_q.mode ||
             wdata_in[bdctl_pkg::RANGE_LSB +: 2] != state_q.range ||
             wdata_in[bdctl_pkg::LOW_FILTER_BIT] != state_q.low_filter)
         begin
            state_d.chan_ready = 1'b0;
         end
         if (wdata_in[bdctl_pkg::SYNC_BIT])
         begin
            if (wdata_in[bdctl_pkg::CLR_ON_SYNC_BIT])
            begin
               state_d.buf_clr_p = 1'b1;
            end
            else
            begin
               state_d.sync_p     = 1'b1;
               state_d.ext_sync_p = wdata_in[bdctl_pkg::INITIATOR_BIT];
            end
         end
         // A second start while a run is busy is ignored
         if (wdata_in[bdctl_pkg::CAL_BIT] && !state_q.cal_busy)
         begin
            state_d.cal_busy    = 1'b1;
            state_d.cal_pass    = 1'b1;
            state_d.cal_start_p = 1'b1;
         end
         if (wdata_in[bdctl_pkg::INIT_CMD_BIT] && !state_q.init_busy)
         begin
            state_d.init_busy    = 1'b1;
            state_d.init_start_p = 1'b1;
         end
      end
      // Set beats a clearing write in the same cycle
      if (irq_event_in)
      begin
         state_d.irq_flag = 1'b1;
      end
      if (rd_in)
      begin
         state_d.rdata = hit ? view : 32'h00000000;
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
      begin
         state_q <= defaults();
      end
      else
      begin
         state_q <= state_d;
      end
   end

   // -------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------
   assign rdata_out                  = state_q.rdata;
   assign input_mode_out             = state_q.mode;
   assign input_range_out            = state_q.range;
   assign offset_binary_out          = state_q.offbin;
   assign initiator_out              = state_q.initiator;
   assign irq_select_out             = state_q.irq_sel;
   assign irq_out                    = state_q.irq_flag;
   assign unsynced_sampling_out      = state_q.unsync;
   assign gen_a_clock_out_select_out = state_q.gen_a_sel;
   assign low_freq_filter_out        = state_q.low_filter;
   assign ttl_sync_io_out            = state_q.ttl_sync;
   assign arm_trigger_out            = state_q.arm_trig;
   assign invert_trigger_out         = state_q.inv_trig;
   assign sync_local_out             = state_q.sync_p;
   assign ext_sync_out               = state_q.ext_sync_p;
   assign buf_clear_out              = state_q.buf_clr_p;
   assign cal_start_out              = state_q.cal_start_p;
   assign init_start_out             = state_q.init_start_p;

   // -------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (sys_rst_in);

   logic wr_hit;
   assign wr_hit = wr_in && hit;

   reset_value_a: assert property ($fell(sys_rst_in) |-> view == bdctl_pkg::BOARD_CONTROL_RST)
      else $error("Readback after reset differs from default");
   full_value_a: assert property (rd_in && hit && !wr_in && view == bdctl_pkg::BOARD_CONTROL_FULL
                                  |=> rdata_out == bdctl_pkg::BOARD_CONTROL_FULL)
      else $error("Full buffer readback not returned");
   sync_pulse_a: assert property (wr_hit && wdata_in[6] && !wdata_in[17]
                                  |=> sync_local_out && !buf_clear_out && ext_sync_out == initiator_out
                                  ##1 !sync_local_out)
      else $error("Software sync pulse wrong");
   clear_buffer_a: assert property (wr_hit && wdata_in[6] && wdata_in[17]
                                    |=> buf_clear_out && !sync_local_out && !ext_sync_out)
      else $error("Buffer clear on sync wrong");
   cal_start_a: assert property (wr_hit && wdata_in[7] && !state_q.cal_busy
                                 |=> cal_start_out && view[7] && view[12])
      else $error("Autocalibration start wrong");
   cal_fail_a: assert property (state_q.cal_busy && cal_done_in && cal_fail_in && !wr_in
                                |=> !view[12] && !view[7])
      else $error("Failed calibration not reported");
   irq_set_a: assert property (irq_event_in |=> irq_out && view[11])
      else $error("Interrupt request not raised");
   irq_clear_a: assert property (wr_hit && !wdata_in[11] && !irq_event_in |=> !irq_out)
      else $error("Interrupt request not withdrawn");
   ready_drop_a: assert property (chan_param_change_in |=> !view[13])
      else $error("Channels ready not dropped");
   // The reset edge loads defaults, so the flag follows the buffer only from the next edge
   thresh_flag_a: assert property (!sys_rst_in |=> view[14] == $past(buf_over_thresh_in))
      else $error("Threshold flag does not follow buffer");
   init_cycle_a: assert property (wr_hit && wdata_in[15] && !state_q.init_busy
                                  |=> init_start_out && view[15] ##1 !init_start_out)
      else $error("Initialization start wrong");
   init_done_a: assert property (state_q.init_busy && init_done_in && !wr_in |=> !view[15])
      else $error("Initialize bit not cleared on completion");
   reserved_zero_a: assert property (view[31:24] == 8'h00 && !view[22] && !view[6])
      else $error("Reserved bits not zero");

   cal_run_c: cover property (cal_start_out ##[1:20] (state_q.cal_busy && cal_done_in));
   init_run_c: cover property (init_start_out ##[1:20] (state_q.init_busy && init_done_in));
   irq_c: cover property (irq_event_in ##1 (wr_hit && !wdata_in[11]));
   clear_c: cover property (buf_clear_out);

endmodule

// File: dv/tb_top.sv
// Self-checking testbench for the board control and status register
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   // -------------------------------------------------------------
   // Signals
   // -------------------------------------------------------------
   logic        clk_in;
   logic        sys_rst_in;
   logic [6:0]  addr_in;
   logic        wr_in;
   logic        rd_in;
   logic [31:0] wdata_in;
   logic        irq_event_in;
   logic        cal_done_in;
   logic        cal_fail_in;
   logic        init_done_in;
   logic        chan_param_change_in;
   logic        adc_clk_stable_in;
   logic        buf_over_thresh_in;
   logic [31:0] rdata_out;
   logic [1:0]  input_mode_out;
   logic [1:0]  input_range_out;
   logic        offset_binary_out;
   logic        initiator_out;
   logic [2:0]  irq_select_out;
   logic        irq_out;
   logic        unsynced_sampling_out;
   logic        gen_a_clock_out_select_out;
   logic        low_freq_filter_out;
   logic        ttl_sync_io_out;
   logic        arm_trigger_out;
   logic        invert_trigger_out;
   logic        sync_local_out;
   logic        ext_sync_out;
   logic        buf_clear_out;
   logic        cal_start_out;
   logic        init_start_out;
   int          miscompares;
   int          compares;
   // Field values written in the main test; bit 22 and the top byte must not stick
   localparam logic [31:0] FIELDS = 32'h00bd0506;

   bdctl_reg bdctl_reg_i (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .addr_in(addr_in), .wr_in(wr_in),
      .rd_in(rd_in), .wdata_in(wdata_in), .irq_event_in(irq_event_in), .cal_done_in(cal_done_in),
      .cal_fail_in(cal_fail_in), .init_done_in(init_done_in), .chan_param_change_in(chan_param_change_in),
      .adc_clk_stable_in(adc_clk_stable_in), .buf_over_thresh_in(buf_over_thresh_in), .rdata_out(rdata_out),
      .input_mode_out(input_mode_out), .input_range_out(input_range_out), .offset_binary_out(offset_binary_out),
      .initiator_out(initiator_out), .irq_select_out(irq_select_out), .irq_out(irq_out),
      .unsynced_sampling_out(unsynced_sampling_out), .gen_a_clock_out_select_out(gen_a_clock_out_select_out),
      .low_freq_filter_out(low_freq_filter_out), .ttl_sync_io_out(ttl_sync_io_out),
      .arm_trigger_out(arm_trigger_out), .invert_trigger_out(invert_trigger_out),
      .sync_local_out(sync_local_out), .ext_sync_out(ext_sync_out), .buf_clear_out(buf_clear_out),
      .cal_start_out(cal_start_out), .init_start_out(init_start_out));

   // -------------------------------------------------------------
   // Clock and access tasks
   // -------------------------------------------------------------
   initial
   begin
      clk_in = 1'b0;
      forever #12.5 clk_in = ~clk_in;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         miscompares++;
         $display("unexpected value at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask

   // Sampling ends 1 ns after the taking edge, so registered pulses are seen in their cycle
   task automatic reg_wr(input logic [6:0] a, input logic [31:0] d);
      @(posedge clk_in);
      wr_in    <= 1'b1;
      addr_in  <= a;
      wdata_in <= d;
      @(posedge clk_in);
      wr_in    <= 1'b0;
      #1;
   endtask

   task automatic reg_rd(input logic [6:0] a, input logic [31:0] exp);
      @(posedge clk_in);
      rd_in   <= 1'b1;
      addr_in <= a;
      @(posedge clk_in);
      rd_in   <= 1'b0;
      @(posedge clk_in);
      #1;
      chk(rdata_out, exp);
   endtask

   task automatic end_test(input string name);
      $display("test %s done, mismatches so far %0d", name, miscompares);
   endtask

   task automatic give_verdict;
      $display("comparisons %0d, mismatches %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // -------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------
   initial
   begin
      miscompares = 0;
      compares = 0;
      sys_rst_in = 1'b1;
      {addr_in, wr_in, rd_in, wdata_in} = '0;
      {irq_event_in, cal_done_in, cal_fail_in, init_done_in} = '0;
      {chan_param_change_in, adc_clk_stable_in, buf_over_thresh_in} = '0;
      repeat (12) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      reg_rd(7'h00, 32'h0000383c);
      chk({offset_binary_out, initiator_out, irq_out, input_range_out, input_mode_out}, 32'h7c);
      end_test("reset");
      // Every writable field but bit 17 moved; status bits 12 to 14 and the reserved bits are written high as well
      reg_wr(7'h00, 32'hfffd7506);
      reg_rd(7'h00, FIELDS | 32'h1000);
      chk({input_mode_out, input_range_out, offset_binary_out, initiator_out}, 32'h24);
      chk(irq_select_out, 32'h5);
      chk({unsynced_sampling_out, gen_a_clock_out_select_out, low_freq_filter_out}, 32'h7);
      chk({ttl_sync_io_out, arm_trigger_out, invert_trigger_out}, 32'h7);
      @(posedge clk_in) adc_clk_stable_in <= 1'b1;
      @(posedge clk_in) adc_clk_stable_in <= 1'b0;
      reg_rd(7'h00, FIELDS | 32'h3000);
      @(posedge clk_in) chan_param_change_in <= 1'b1;
      reg_rd(7'h00, FIELDS | 32'h1000);
      @(posedge clk_in) chan_param_change_in <= 1'b0;
      @(posedge clk_in) adc_clk_stable_in <= 1'b1;
      @(posedge clk_in) adc_clk_stable_in <= 1'b0;
      reg_rd(7'h00, FIELDS | 32'h3000);
      end_test("fields");
      // Sync as target, as initiator, then as buffer clear
      reg_wr(7'h00, FIELDS | 32'h40);
      chk({sync_local_out, ext_sync_out, buf_clear_out}, 32'h4);
      @(posedge clk_in);
      #1;
      chk(sync_local_out, 32'h0);
      reg_rd(7'h00, FIELDS | 32'h3000);
      reg_wr(7'h00, FIELDS | 32'h60);
      chk({sync_local_out, ext_sync_out, buf_clear_out}, 32'h6);
      reg_wr(7'h00, FIELDS | 32'h20060);
      chk({sync_local_out, ext_sync_out, buf_clear_out}, 32'h1);
      end_test("sync");
      // Failed calibration, then a good one that sets the pass flag again
      reg_wr(7'h00, FIELDS | 32'h200a0);
      chk(cal_start_out, 32'h1);
      reg_rd(7'h00, FIELDS | 32'h230a0);
      @(posedge clk_in);
      cal_done_in <= 1'b1;
      cal_fail_in <= 1'b1;
      @(posedge clk_in);
      cal_done_in <= 1'b0;
      cal_fail_in <= 1'b0;
      reg_rd(7'h00, FIELDS | 32'h22020);
      reg_wr(7'h00, FIELDS | 32'h200a0);
      reg_rd(7'h00, FIELDS | 32'h230a0);
      reg_wr(7'h00, FIELDS | 32'h200a0);
      chk(cal_start_out, 32'h0);
      @(posedge clk_in) cal_done_in <= 1'b1;
      @(posedge clk_in) cal_done_in <= 1'b0;
      reg_rd(7'h00, FIELDS | 32'h23020);
      end_test("calibration");
      // Initialization restores the writable defaults
      reg_wr(7'h00, FIELDS | 32'h28020);
      chk(init_start_out, 32'h1);
      reg_rd(7'h00, FIELDS | 32'h2b020);
      @(posedge clk_in) init_done_in <= 1'b1;
      @(posedge clk_in) init_done_in <= 1'b0;
      reg_rd(7'h00, 32'h0000303c);
      end_test("initialize");
      // Request flag: event sets, a clearing write in the same cycle loses
      @(posedge clk_in) irq_event_in <= 1'b1;
      @(posedge clk_in) irq_event_in <= 1'b0;
      #1;
      chk(irq_out, 32'h1);
      reg_rd(7'h00, 32'h0000383c);
      @(posedge clk_in);
      irq_event_in <= 1'b1;
      wr_in        <= 1'b1;
      addr_in      <= 7'h00;
      wdata_in     <= 32'h0000003c;
      @(posedge clk_in);
      irq_event_in <= 1'b0;
      wr_in        <= 1'b0;
      #1;
      chk(irq_out, 32'h1);
      reg_wr(7'h00, 32'h0000003c);
      chk(irq_out, 32'h0);
      reg_wr(7'h00, 32'h0000083c);
      reg_rd(7'h00, 32'h0000303c);
      end_test("request");
      // Other local offsets neither store nor return data
      reg_wr(7'h04, 32'hffffffff);
      reg_rd(7'h00, 32'h0000303c);
      reg_rd(7'h04, 32'h00000000);
      end_test("decode");
      // Second reset with the buffer above threshold
      @(posedge clk_in);
      sys_rst_in         <= 1'b1;
      buf_over_thresh_in <= 1'b1;
      repeat (3) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      reg_rd(7'h00, 32'h0000783c);
      @(posedge clk_in) buf_over_thresh_in <= 1'b0;
      reg_rd(7'h00, 32'h0000383c);
      end_test("threshold");
      give_verdict();
   end
endmodule
